// ===== verilog/cct_pkg.sv
// Constants, types and field layouts of the CAN core timing and message manager
package cct_pkg;
    localparam int N_OBJ    = 32;
    localparam int OBJ_W    = 5;
    localparam int SCR_W    = 30;
    localparam int MASK_W   = 29;
    localparam int FIFO_DEP = 32;

    // Register offsets
    localparam logic [9:0] OFS_CMD   = 10'h270;
    localparam logic [9:0] OFS_BTR   = 10'h272;
    localparam logic [9:0] OFS_OPT   = 10'h274;
    localparam logic [9:0] OBJ_LIMIT = 10'h200;
    localparam logic [3:0] OFS_MIDH  = 4'h0;
    localparam logic [3:0] OFS_MIDL  = 4'h2;
    localparam logic [3:0] OFS_MSKH  = 4'h4;
    localparam logic [3:0] OFS_MSKL  = 4'h6;
    localparam logic [3:0] OFS_CTL   = 4'h8;
    localparam logic [3:0] OFS_BLR   = 4'ha;
    localparam logic [3:0] OFS_BSZ   = 4'hc;

    // Reset values and writable bits
    localparam logic [15:0] BTR_RST   = 16'h0000;
    localparam logic [7:0]  CMD_RST   = 8'h01;
    localparam logic [7:0]  CMD_WMASK = 8'hed;
    localparam int          CMD_RR    = 0;

    // Object control bits and the option register bit
    localparam int CTL_EN   = 0;
    localparam int CTL_TX   = 1;
    localparam int CTL_ASM  = 2;
    localparam int CTL_PEND = 3;
    localparam int CTL_RMT  = 4;
    localparam int CTL_CIRC = 5;
    localparam int OPT_ALT  = 0;

    typedef struct packed {
        logic       triple;
        logic [2:0] seg2;
        logic [3:0] seg1;
        logic [1:0] resync_jump_width;
        logic [5:0] quantum_prescaler;
    } cct_btr_t;

    typedef struct packed {
        logic             circ;
        logic             assemble;
        logic [OBJ_W-1:0] obj;
        logic [SCR_W-1:0] scr;
    } cct_rec_t;

    typedef enum logic [1:0] {
        PH_SYNC = 2'b00,
        PH_SEG1 = 2'b01,
        PH_SEG2 = 2'b10
    } cct_phase_t;
endpackage : cct_pkg

// ===== verilog/cct_core.sv
// CAN core bit timing, mode control, acceptance filter, pre-arbitration and record FIFO
`timescale 1ns/1ns

// Record FIFO between acceptance filter and message handler
module cct_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest full and empty from occupancy
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule : cct_fifo

module cct_core
    import cct_pkg::*;
#(
    parameter int NOBJ = N_OBJ
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [9:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire logic             reg_word,
    input  wire logic [15:0]      reg_wdata,
    output logic [15:0]           reg_rdata,
    input  wire logic             can_rx,
    input  wire logic             tx_buffer_underflow,
    input  wire logic             bus_off,
    input  wire logic             test_mode,
    input  wire logic             id_valid,
    output logic                  id_ready,
    input  wire logic [SCR_W-1:0] id_screener,
    input  wire logic             tx_done,
    input  wire logic [OBJ_W-1:0] tx_done_obj,
    output logic                  operation_mode,
    output logic                  tq_tick,
    output logic                  sample_pulse,
    output logic                  sampled_bit,
    output logic                  tx_sel_valid,
    output logic [OBJ_W-1:0]      tx_sel_obj,
    output logic                  tx_sel_remote,
    output logic                  rec_valid,
    input  wire logic             rec_ready,
    output cct_rec_t              rec_data
);
    cct_btr_t         btr_reg;
    logic [7:0]       cmd_reg;
    logic [7:0]       opt_reg;
    logic [15:0]      mid_hi [NOBJ];
    logic [15:0]      mid_lo [NOBJ];
    logic [15:0]      msk_hi [NOBJ];
    logic [15:0]      msk_lo [NOBJ];
    logic [7:0]       ctl    [NOBJ];
    logic [15:0]      blr    [NOBJ];
    logic [7:0]       bsz    [NOBJ];
    logic             rx_meta_reg;
    logic             rx_sync_reg;
    logic [6:0]       presc_reg;
    cct_phase_t       phase_reg;
    logic [4:0]       q_reg;
    logic [4:0]       seg1_len_reg;
    logic [3:0]       seg2_len_reg;
    logic             resynced_reg;
    logic             rx_prev_reg;
    logic [1:0]       hist_reg;
    logic             sample_pulse_reg;
    logic             sampled_bit_reg;
    logic             tx_sel_valid_reg;
    logic [OBJ_W-1:0] tx_sel_obj_reg;
    logic             tx_sel_remote_reg;
    logic [15:0]      rdata_reg;
    logic             wr_cmd;
    logic             wr_obj;
    logic [OBJ_W-1:0] obj_idx;
    logic [6:0]       presc_lim;
    logic             edge_fall;
    logic [4:0]       sjw1;
    logic [4:0]       q1;
    logic [4:0]       seg1_len_next;
    logic [4:0]       seg2_end;
    logic             majority;
    logic             hit;
    logic [OBJ_W-1:0] hit_obj;
    logic             best_valid;
    logic [OBJ_W-1:0] best_obj;
    logic [28:0]      best_id;
    cct_rec_t         rec_in;

    assign operation_mode = !cmd_reg[CMD_RR];
    assign obj_idx        = reg_addr[8:4];
    assign wr_cmd         = reg_wr && (reg_addr == OFS_CMD);
    assign wr_obj         = reg_wr && reg_word && (reg_addr < OBJ_LIMIT);

    // Bus pin synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= can_rx;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Command: request set by reset and hardware events, set beats clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= CMD_RST;
        end else begin
            if (wr_cmd) begin
                cmd_reg <= reg_wdata[7:0] & CMD_WMASK;
            end
            if (tx_buffer_underflow || bus_off || test_mode) begin
                cmd_reg[CMD_RR] <= 1'b1;
            end
        end
    end

    // Bit timing word, word writes in reset mode only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            btr_reg <= cct_btr_t'(BTR_RST);
            opt_reg <= '0;
        end else begin
            if (reg_wr && reg_word && cmd_reg[CMD_RR] && reg_addr == OFS_BTR) begin
                btr_reg <= cct_btr_t'(reg_wdata);
            end
            if (reg_wr && reg_addr == OFS_OPT) begin
                opt_reg <= reg_wdata[7:0];
            end
        end
    end

    // Object registers, control pending cleared by finished transmission
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NOBJ; i++) begin
                mid_hi[i] <= '0;
                mid_lo[i] <= '0;
                msk_hi[i] <= '0;
                msk_lo[i] <= '0;
                ctl[i]    <= '0;
                blr[i]    <= '0;
                bsz[i]    <= '0;
            end
        end else begin
            if (tx_done) begin
                ctl[tx_done_obj][CTL_PEND] <= 1'b0;
            end
            if (wr_obj) begin
                case (reg_addr[3:0])
                    OFS_MIDH: mid_hi[obj_idx] <= reg_wdata;
                    OFS_MIDL: mid_lo[obj_idx] <= reg_wdata;
                    OFS_MSKH: msk_hi[obj_idx] <= reg_wdata;
                    OFS_MSKL: msk_lo[obj_idx] <= reg_wdata;
                    OFS_CTL:  ctl[obj_idx]    <= reg_wdata[7:0];
                    OFS_BLR:  blr[obj_idx]    <= reg_wdata;
                    OFS_BSZ:  bsz[obj_idx]    <= reg_wdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Quantum prescaler: 2*(brp+1) clocks per quantum
    assign presc_lim = {btr_reg.quantum_prescaler, 1'b1};
    assign tq_tick   = operation_mode && (presc_reg == presc_lim);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= '0;
        end else if (!operation_mode || tq_tick) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 1'b1;
        end
    end

    // Resync arithmetic per quantum
    assign edge_fall = rx_prev_reg && !rx_sync_reg && !resynced_reg;
    assign sjw1      = {3'b000, btr_reg.resync_jump_width} + 5'd1;
    assign q1        = q_reg + 5'd1;
    always_comb begin
        seg1_len_next = seg1_len_reg;
        if (edge_fall) begin
            seg1_len_next = seg1_len_reg + ((q1 < sjw1) ? q1 : sjw1);
        end
        seg2_end = {1'b0, seg2_len_reg};
        if (edge_fall) begin
            seg2_end = (seg2_end > sjw1) ? seg2_end - sjw1 : 5'd0;
        end
        if (seg2_end < q1) begin
            seg2_end = q1;
        end
    end

    // Majority of current and two previous quanta
    assign majority = (hist_reg[0] & hist_reg[1]) | (hist_reg[0] & rx_sync_reg) | (hist_reg[1] & rx_sync_reg);

    // Bit phase sequencer: sync, seg1, seg2
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg    <= PH_SYNC;
            q_reg        <= '0;
            seg1_len_reg <= '0;
            seg2_len_reg <= '0;
            resynced_reg <= 1'b0;
        end else if (!operation_mode) begin
            phase_reg    <= PH_SYNC;
            q_reg        <= '0;
            resynced_reg <= 1'b0;
        end else if (tq_tick) begin
            case (phase_reg)
                PH_SYNC: begin
                    phase_reg    <= PH_SEG1;
                    q_reg        <= '0;
                    seg1_len_reg <= {1'b0, btr_reg.seg1} + 5'd1;
                    resynced_reg <= 1'b0;
                end
                PH_SEG1: begin
                    seg1_len_reg <= seg1_len_next;
                    if (edge_fall) begin
                        resynced_reg <= 1'b1;
                    end
                    if (q1 >= seg1_len_next) begin
                        phase_reg    <= PH_SEG2;
                        q_reg        <= '0;
                        seg2_len_reg <= {1'b0, btr_reg.seg2} + 4'd1;
                    end else begin
                        q_reg <= q1;
                    end
                end
                PH_SEG2: begin
                    if (edge_fall) begin
                        resynced_reg <= 1'b1;
                    end
                    if (q1 >= seg2_end) begin
                        phase_reg <= PH_SYNC;
                        q_reg     <= '0;
                    end else begin
                        q_reg <= q1;
                    end
                end
                default: begin
                    phase_reg <= PH_SYNC;
                    q_reg     <= '0;
                end
            endcase
        end
    end

    // Sampling at end of seg1, single or triple
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev_reg      <= 1'b1;
            hist_reg         <= 2'b11;
            sample_pulse_reg <= 1'b0;
            sampled_bit_reg  <= 1'b1;
        end else begin
            sample_pulse_reg <= 1'b0;
            if (tq_tick) begin
                rx_prev_reg <= rx_sync_reg;
                hist_reg    <= {hist_reg[0], rx_sync_reg};
                if (phase_reg == PH_SEG1 && q1 >= seg1_len_next) begin
                    sample_pulse_reg <= 1'b1;
                    sampled_bit_reg  <= btr_reg.triple ? majority : rx_sync_reg;
                end
            end
        end
    end

    assign sample_pulse = sample_pulse_reg;
    assign sampled_bit  = sampled_bit_reg;

    // Acceptance filter: lowest matching receive object
    always_comb begin
        logic [SCR_W-1:0] care;
        logic [SCR_W-1:0] match;
        care    = '0;
        match   = '0;
        hit     = 1'b0;
        hit_obj = '0;
        for (int i = NOBJ - 1; i >= 0; i--) begin
            care  = {~{msk_hi[i], msk_lo[i][15:3]}, 1'b1};
            match = {mid_hi[i], mid_lo[i][15:2]};
            if (ctl[i][CTL_EN] && !ctl[i][CTL_TX] && (((id_screener ^ match) & care) == '0)) begin
                hit     = 1'b1;
                hit_obj = OBJ_W'(i);
            end
        end
    end

    // Record tells handler whether to assemble or store singly
    assign rec_in.circ     = ctl[hit_obj][CTL_CIRC];
    assign rec_in.assemble = ctl[hit_obj][CTL_ASM];
    assign rec_in.obj      = hit_obj;
    assign rec_in.scr      = id_screener;

    cct_fifo #(
        .WIDTH ($bits(cct_rec_t)),
        .DEPTH (FIFO_DEP)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (id_valid && hit && operation_mode),
        .in_ready  (id_ready),
        .in_data   (rec_in),
        .out_valid (rec_valid),
        .out_ready (rec_ready),
        .out_data  (rec_data)
    );

    // Transmit pre-arbitration among pending objects
    always_comb begin
        logic [28:0] cid;
        cid        = '0;
        best_valid = 1'b0;
        best_obj   = '0;
        best_id    = '0;
        for (int i = 0; i < NOBJ; i++) begin
            cid = {mid_hi[i], mid_lo[i][15:3]};
            if (ctl[i][CTL_EN] && ctl[i][CTL_TX] && ctl[i][CTL_PEND]) begin
                if (!best_valid || (!opt_reg[OPT_ALT] && cid < best_id)) begin
                    best_valid = 1'b1;
                    best_obj   = OBJ_W'(i);
                    best_id    = cid;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_sel_valid_reg  <= 1'b0;
            tx_sel_obj_reg    <= '0;
            tx_sel_remote_reg <= 1'b0;
        end else begin
            tx_sel_valid_reg  <= best_valid && operation_mode;
            tx_sel_obj_reg    <= best_obj;
            tx_sel_remote_reg <= ctl[best_obj][CTL_RMT];
        end
    end

    assign tx_sel_valid  = tx_sel_valid_reg;
    assign tx_sel_obj    = tx_sel_obj_reg;
    assign tx_sel_remote = tx_sel_remote_reg;

    // Register read, one cycle after strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            if (reg_addr == OFS_CMD) begin
                rdata_reg <= {8'h00, cmd_reg};
            end else if (reg_addr == OFS_BTR) begin
                rdata_reg <= btr_reg;
            end else if (reg_addr == OFS_OPT) begin
                rdata_reg <= {8'h00, opt_reg};
            end else if (reg_addr < OBJ_LIMIT) begin
                case (reg_addr[3:0])
                    OFS_MIDH: rdata_reg <= mid_hi[obj_idx];
                    OFS_MIDL: rdata_reg <= mid_lo[obj_idx];
                    OFS_MSKH: rdata_reg <= msk_hi[obj_idx];
                    OFS_MSKL: rdata_reg <= msk_lo[obj_idx];
                    OFS_CTL:  rdata_reg <= {8'h00, ctl[obj_idx]};
                    OFS_BLR:  rdata_reg <= blr[obj_idx];
                    OFS_BSZ:  rdata_reg <= {8'h00, bsz[obj_idx]};
                    default:  rdata_reg <= '0;
                endcase
            end else begin
                rdata_reg <= '0;
            end
        end
    end

    assign reg_rdata = rdata_reg;
endmodule : cct_core

// ===== testbench/cct_core_assertions.sv
// Port checks on the core: mode, register reads and bit timing
`timescale 1ns/1ns
module cct_core_checker
    import cct_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [9:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_word,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        can_rx,
    input wire logic        tx_buffer_underflow,
    input wire logic        bus_off,
    input wire logic        test_mode,
    input wire logic        operation_mode,
    input wire logic        tq_tick,
    input wire logic        sample_pulse,
    input wire logic        sampled_bit,
    input wire logic        rec_valid,
    input wire logic        rec_ready,
    input wire cct_rec_t    rec_data
);
    logic [15:0] btr_sh;
    logic [11:0] tgap, sgap;
    logic        tq_ok, s_ok, edg, edg_prev, rx_q;
    int          q, bitc, jw;
    // Quantum, bit and jump lengths in clocks
    assign q    = 2 * (btr_sh[5:0] + 1);
    assign bitc = q * (btr_sh[11:8] + btr_sh[14:12] + 3);
    assign jw   = q * (btr_sh[7:6] + 1);
    // Shadow of the bit timing word, taken only in reset mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            btr_sh <= 16'h0000;
        end else if (reg_wr && reg_word && !operation_mode && reg_addr == OFS_BTR) begin
            btr_sh <= reg_wdata;
        end
    end
    // Gaps between ticks and samples, and bus edges seen per bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tgap     <= 12'h000;
            sgap     <= 12'h000;
            tq_ok    <= 1'b0;
            s_ok     <= 1'b0;
            edg      <= 1'b0;
            edg_prev <= 1'b0;
            rx_q     <= 1'b1;
        end else begin
            tgap     <= tq_tick ? 12'h000 : tgap + 12'h001;
            sgap     <= sample_pulse ? 12'h000 : sgap + 12'h001;
            tq_ok    <= operation_mode && (tq_tick || tq_ok);
            s_ok     <= operation_mode && (sample_pulse || s_ok);
            edg      <= sample_pulse ? (can_rx != rx_q) : (edg || can_rx != rx_q);
            edg_prev <= sample_pulse ? edg : edg_prev;
            rx_q     <= can_rx;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_hw_event;
        tx_buffer_underflow || bus_off || test_mode;
    endsequence
    sequence s_clear_req;
        reg_wr && reg_addr == OFS_CMD && !reg_wdata[0] && !(tx_buffer_underflow || bus_off || test_mode);
    endsequence
    a_reset_entry: assert property ($rose(rst_n) |-> !operation_mode)
        else $error("not in reset mode after reset");
    a_clear_request: assert property (s_clear_req |=> operation_mode)
        else $error("no operation after clear");
    a_hw_request: assert property (s_hw_event |=> !operation_mode)
        else $error("event left core running");
    a_btr_read: assert property (reg_rd && !reg_wr && reg_addr == OFS_BTR |=> reg_rdata == btr_sh)
        else $error("bit timing read wrong");
    a_cmd_read: assert property (reg_rd && !reg_wr && reg_addr == OFS_CMD
        |=> reg_rdata[0] == !$past(operation_mode)) else $error("reset request bit wrong");
    a_quantum_gap: assert property (tq_tick && tq_ok |-> tgap == q - 1)
        else $error("quantum length wrong");
    a_sample_tick: assert property (sample_pulse |-> $past(tq_tick))
        else $error("sample off a quantum tick");
    a_bit_plain: assert property (sample_pulse && s_ok && !edg && !edg_prev
        |-> sgap == bitc - 1) else $error("bit length wrong");
    a_bit_resync: assert property (sample_pulse && s_ok
        |-> sgap >= bitc - 1 - jw && sgap <= bitc - 1 + jw) else $error("resync beyond jump width");
    a_bit_hold: assert property ($changed(sampled_bit) |-> sample_pulse)
        else $error("bit changed off sample");
    a_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
        else $error("record dropped while stalled");
endmodule : cct_core_checker

// ===== testbench/cct_bus_node.sv
// Behavioural CAN node driving the core's receive line
`timescale 1ns/1ns
module cct_bus_node #(
    parameter int BIT_NS = 1450
) (
    output logic can_rx
);
    // Recessive while no frame is on the bus
    initial begin
        can_rx = 1'b1;
    end
    // Hold a level for some bits, slightly off rate, then release
    task automatic send(input logic lvl, input int nbits);
        can_rx = lvl;
        #(nbits * BIT_NS);
        can_rx = 1'b1;
    endtask : send
endmodule : cct_bus_node

// ===== testbench/cct_core_bench.sv
// Self-checking bench of the CAN core
`timescale 1ns/1ns
module cct_core_bench;
    import cct_pkg::*;
    typedef struct { logic [9:0] a; logic [15:0] d; logic [15:0] e; } cct_row_t;
    logic        clk_sys, rst_n, reg_wr, reg_rd, reg_word, can_rx, tx_buffer_underflow, bus_off, test_mode;
    logic        id_valid, tx_done, rec_ready, id_ready, operation_mode, tq_tick, sample_pulse, sampled_bit;
    logic        tx_sel_valid, tx_sel_remote, rec_valid;
    logic [9:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [29:0] id_screener;
    logic [4:0]  tx_done_obj, tx_sel_obj;
    cct_rec_t    rec_data;
    int          fails, tests_run, n;
    cct_row_t    rows [14] = '{'{10'h272, 16'h2441, 16'h2441}, '{10'h270, 16'h00e5, 16'h00e5},
        '{10'h270, 16'h0001, 16'h0001}, '{10'h274, 16'h0001, 16'h0001}, '{10'h274, 16'h0000, 16'h0000},
        '{10'h3f0, 16'h1234, 16'h0000}, '{10'h030, 16'h1234, 16'h1234}, '{10'h032, 16'h5678, 16'h5678},
        '{10'h036, 16'h0008, 16'h0008}, '{10'h038, 16'h0001, 16'h0001}, '{10'h010, 16'h0400, 16'h0400},
        '{10'h018, 16'h000b, 16'h000b}, '{10'h040, 16'h0100, 16'h0100}, '{10'h048, 16'h001b, 16'h001b}};
    cct_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_word(reg_word), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .can_rx(can_rx),
        .tx_buffer_underflow(tx_buffer_underflow), .bus_off(bus_off), .test_mode(test_mode),
        .id_valid(id_valid), .id_ready(id_ready), .id_screener(id_screener), .tx_done(tx_done),
        .tx_done_obj(tx_done_obj), .operation_mode(operation_mode), .tq_tick(tq_tick),
        .sample_pulse(sample_pulse), .sampled_bit(sampled_bit), .tx_sel_valid(tx_sel_valid),
        .tx_sel_obj(tx_sel_obj), .tx_sel_remote(tx_sel_remote), .rec_valid(rec_valid),
        .rec_ready(rec_ready), .rec_data(rec_data));
    cct_bus_node node_u (.can_rx(can_rx));
    // 25 MHz clock
    always begin
        #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [36:0] e, input logic [36:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic w, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr  = a;
        reg_word  = w;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr    = 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        reg_rd   = 1'b0;
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic push(input logic [29:0] s);
        @(negedge clk_sys);
        id_screener = s;
        id_valid    = 1'b1;
        @(negedge clk_sys);
        id_valid    = 1'b0;
    endtask : push
    task automatic ev(input int k);
        @(negedge clk_sys);
        {test_mode, bus_off, tx_buffer_underflow} = 3'b001 << k;
        @(negedge clk_sys);
        {test_mode, bus_off, tx_buffer_underflow} = 3'b000;
    endtask : ev
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog against a hang
    initial begin
        #1600000;
        fails++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        {clk_sys, rst_n, reg_wr, reg_rd, reg_word, tx_buffer_underflow, bus_off, test_mode} = 8'h00;
        {id_valid, tx_done, rec_ready, reg_addr, reg_wdata, id_screener, tx_done_obj} = 64'h0;
        fails     = 0;
        tests_run = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk("operation_mode", 0, operation_mode);
        rd(10'h272, 16'h0000);
        rd(10'h270, 16'h0001);
        foreach (rows[i]) begin
            wr(rows[i].a, 1'b1, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(10'h272, 1'b0, 16'h00ff);
        rd(10'h272, 16'h2441);
        wr(10'h270, 1'b1, 16'h0000);
        chk("operation_mode", 1, operation_mode);
        wr(10'h272, 1'b1, 16'h0000);
        rd(10'h272, 16'h2441);
        // Filter: one miss, one masked hit, then fill and drain the record FIFO
        push(30'h048d559e);
        @(negedge clk_sys);
        chk("rec_valid", 0, rec_valid);
        push(30'h048d159c);
        chk("rec_data", {2'b00, 5'd3, 30'h048d159c}, rec_data);
        for (int i = 0; i < 31; i++) begin
            push(30'h048d159e);
        end
        chk("id_ready", 0, id_ready);
        rec_ready = 1'b1;
        n         = 0;
        repeat (40) begin
            n += rec_valid;
            @(negedge clk_sys);
        end
        chk("records", 32, n);
        // Pre-arbitration by identifier, by number, and after completion
        chk("tx_sel", {1'b1, 5'd4, 1'b1}, {tx_sel_valid, tx_sel_obj, tx_sel_remote});
        wr(10'h274, 1'b1, 16'h0001);
        @(negedge clk_sys);
        chk("tx_sel", {1'b1, 5'd1, 1'b0}, {tx_sel_valid, tx_sel_obj, tx_sel_remote});
        wr(10'h274, 1'b1, 16'h0000);
        tx_done_obj = 5'd4;
        tx_done     = 1'b1;
        @(negedge clk_sys);
        tx_done     = 1'b0;
        @(negedge clk_sys);
        chk("tx_sel", {1'b1, 5'd1, 1'b0}, {tx_sel_valid, tx_sel_obj, tx_sel_remote});
        // Each hardware event forces reset mode
        for (int k = 0; k < 3; k++) begin
            ev(k);
            chk("operation_mode", 0, operation_mode);
            rd(10'h270, 16'h0001);
            wr(10'h270, 1'b1, 16'h0000);
        end
        // Single then triple sampling of driven bus levels
        for (int t = 0; t < 2; t++) begin
            if (t == 1) begin
                ev(0);
                wr(10'h272, 1'b1, 16'ha441);
                rd(10'h272, 16'ha441);
                wr(10'h270, 1'b1, 16'h0000);
            end
            #1960; // Falling edge lands in seg1 of the second bit
            node_u.send(1'b0, 3);
            chk("sampled_bit", 0, sampled_bit);
            #4330;
            chk("sampled_bit", 1, sampled_bit);
        end
        report_and_stop;
    end
endmodule : cct_core_bench
bind cct_core cct_core_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_word(reg_word), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .can_rx(can_rx),
    .tx_buffer_underflow(tx_buffer_underflow), .bus_off(bus_off), .test_mode(test_mode),
    .operation_mode(operation_mode), .tq_tick(tq_tick), .sample_pulse(sample_pulse),
    .sampled_bit(sampled_bit), .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data));
